//--- core/valve_proving_sequencer.sv
// Valve seat proving sequencer with its configuration menu
// Function
// - Schedule is never, before, after, both or split
// - Never: no seat testing anywhere
// - Before: full test alongside pre-purge
// - After: full test when run ends
// - Both: full test at both points
// - Split: high test before, low test after
// - Every interval within ten percent of nominal
// - Low-pressure phase first, then high-pressure phase
// - Downstream valve alone on for 4 s
// - Ignore switch 3 s after downstream closes
// - Low monitor: switch active means lockout
// - Upstream valve alone on for 4 s
// - Ignore switch 3 s after upstream closes
// - High monitor: switch inactive means lockout
// - Test time steps 1 s, 10 s, 1 min
// - Menu entry only in standby or lockout
// - Password digits are 7 then 8
// - Settings commit after reset held five seconds
// - Pre-purge: both demand inputs means lockout
// - Pre-purge: proving demand with never means lockout
`timescale 1ns/1ps

module valve_proving_sequencer #(
   parameter int unsigned TICKS_PER_SEC = valve_prove_pkg::ONE_SEC_CYCLES,
   parameter int unsigned HOLD_CYCLES = valve_prove_pkg::COMMIT_HOLD_CYCLES
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic proving_pressure_switch,
   input wire logic plain_demand_input,
   input wire logic proving_demand_input,
   input wire logic reset_button,
   input wire logic standby_active,
   input wire logic prepurge_active,
   input wire logic run_active,
   input wire logic menu_request,
   input wire logic menu_exit,
   input wire logic key_valid,
   input wire logic [3:0] key_digit,
   input wire logic schedule_set,
   input wire logic [2:0] schedule_sel,
   input wire logic time_up,
   input wire logic time_down,
   output logic upstream_valve_output,
   output logic downstream_valve_output,
   output logic lockout_active,
   output logic proving_busy,
   output logic menu_unlocked,
   output logic [2:0] schedule,
   output logic [11:0] test_time_s
);

   // ---------------------------------------------------------------
   // Types and state
   // ---------------------------------------------------------------
   typedef enum logic [7:0] {
      st_idle = 8'h01,
      st_vent = 8'h02,
      st_vent_settle = 8'h04,
      st_vent_watch = 8'h08,
      st_fill = 8'h10,
      st_fill_settle = 8'h20,
      st_fill_watch = 8'h40,
      st_lockout = 8'h80
   } prove_state_type;

   typedef enum logic [3:0] {
      menu_closed = 4'h1,
      menu_digit1 = 4'h2,
      menu_digit2 = 4'h4,
      menu_open = 4'h8
   } menu_state_type;

   localparam int unsigned NP = valve_prove_pkg::PIN_COUNT;

   logic [NP-1:0] pin_meta;
   logic [NP-1:0] pin_sync;
   logic sw_on, plain_on, proving_on, button_on, button_prev;
   logic prepurge_prev, run_prev, prepurge_start, run_end, demand_fault;
   prove_state_type state, next_state;
   menu_state_type menu_state, next_menu_state;
   logic do_high, next_do_high;
   logic [31:0] div, next_div;
   logic [11:0] elapsed, next_elapsed;
   logic tick;
   logic [31:0] hold_cnt, next_hold_cnt;
   logic commit;
   logic [2:0] pend_sched, next_pend_sched;
   logic [11:0] pend_time, next_pend_time;
   logic [2:0] next_schedule;
   logic [11:0] next_test_time;

   // Step size of the test time setting around a value, per direction
   function automatic logic [11:0] time_step(input logic [11:0] t,
                                             input logic up);
      if (up ? t < valve_prove_pkg::STEP_BREAK_LOW
             : t <= valve_prove_pkg::STEP_BREAK_LOW)
         time_step = valve_prove_pkg::STEP_FINE;
      else if (up ? t < valve_prove_pkg::STEP_BREAK_HIGH
                  : t <= valve_prove_pkg::STEP_BREAK_HIGH)
         time_step = valve_prove_pkg::STEP_MID;
      else
         time_step = valve_prove_pkg::STEP_COARSE;
   endfunction

   // Last cycle of a phase; a zero length ends the phase at once
   function automatic logic phase_done(input logic [11:0] secs,
                                       input logic [11:0] limit,
                                       input logic on_tick);
      phase_done = (limit == 12'h000) ||
                   (on_tick && secs + 12'h001 >= limit);
   endfunction

   // ---------------------------------------------------------------
   // Pin synchronisers and edge history
   // ---------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         pin_meta <= '0;
         pin_sync <= '0;
         button_prev <= 1'b0;
         prepurge_prev <= 1'b0;
         run_prev <= 1'b0;
      end else begin
         pin_meta <= {reset_button, proving_demand_input,
                      plain_demand_input, proving_pressure_switch};
         pin_sync <= pin_meta;
         button_prev <= pin_sync[valve_prove_pkg::PIN_BUTTON];
         prepurge_prev <= prepurge_active;
         run_prev <= run_active;
      end
   end

   // Decoded pin levels and burner sequence points
   assign sw_on = pin_sync[valve_prove_pkg::PIN_SWITCH];
   assign plain_on = pin_sync[valve_prove_pkg::PIN_PLAIN];
   assign proving_on = pin_sync[valve_prove_pkg::PIN_PROVING];
   assign button_on = pin_sync[valve_prove_pkg::PIN_BUTTON];
   assign prepurge_start = prepurge_active && !prepurge_prev;
   assign run_end = run_prev && !run_active;
   assign demand_fault = prepurge_active && proving_on &&
      (plain_on || schedule == valve_prove_pkg::sched_never);

   // ---------------------------------------------------------------
   // Proving sequencer
   // ---------------------------------------------------------------
   // Exact one-second tick restarted on every phase entry
   assign tick = div == TICKS_PER_SEC - 1;

   always_comb begin
      next_state = state;
      next_do_high = do_high;
      unique case (state)
         st_idle: begin
            if (prepurge_start) begin
               unique case (schedule)
                  valve_prove_pkg::sched_before,
                  valve_prove_pkg::sched_both: begin
                     next_state = st_vent;
                     next_do_high = 1'b1;
                  end
                  valve_prove_pkg::sched_split: begin
                     next_state = st_fill;
                     next_do_high = 1'b0;
                  end
                  default: next_state = st_idle;
               endcase
            end else if (run_end) begin
               unique case (schedule)
                  valve_prove_pkg::sched_after,
                  valve_prove_pkg::sched_both: begin
                     next_state = st_vent;
                     next_do_high = 1'b1;
                  end
                  valve_prove_pkg::sched_split: begin
                     next_state = st_vent;
                     next_do_high = 1'b0;
                  end
                  default: next_state = st_idle;
               endcase
            end
         end
         st_vent:
            if (phase_done(elapsed, valve_prove_pkg::FILL_TIME_S, tick))
               next_state = st_vent_settle;
         st_vent_settle:
            if (phase_done(elapsed, valve_prove_pkg::SETTLE_TIME_S, tick))
               next_state = st_vent_watch;
         st_vent_watch:
            if (sw_on)
               next_state = st_lockout;
            else if (phase_done(elapsed, test_time_s, tick))
               next_state = do_high ? st_fill : st_idle;
         st_fill:
            if (phase_done(elapsed, valve_prove_pkg::FILL_TIME_S, tick))
               next_state = st_fill_settle;
         st_fill_settle:
            if (phase_done(elapsed, valve_prove_pkg::SETTLE_TIME_S, tick))
               next_state = st_fill_watch;
         st_fill_watch:
            if (!sw_on)
               next_state = st_lockout;
            else if (phase_done(elapsed, test_time_s, tick))
               next_state = st_idle;
         st_lockout:
            if (button_prev && !button_on)
               next_state = st_idle;
         default: next_state = st_lockout;
      endcase
      // Demand wiring faults win over any step and keep lockout held
      if (demand_fault)
         next_state = st_lockout;
      next_div = (next_state != state || tick) ? '0 : div + 32'h1;
      next_elapsed = (next_state != state) ? '0 :
         (tick ? elapsed + 12'h001 : elapsed);
   end

   // Sequencer registers and registered valve drives
   always_ff @(posedge clk) begin
      if (srst) begin
         state <= st_idle;
         do_high <= 1'b0;
         div <= '0;
         elapsed <= '0;
         upstream_valve_output <= 1'b0;
         downstream_valve_output <= 1'b0;
         lockout_active <= 1'b0;
         proving_busy <= 1'b0;
      end else begin
         state <= next_state;
         do_high <= next_do_high;
         div <= next_div;
         elapsed <= next_elapsed;
         upstream_valve_output <= next_state == st_fill;
         downstream_valve_output <= next_state == st_vent;
         lockout_active <= next_state == st_lockout;
         proving_busy <= next_state != st_idle &&
                         next_state != st_lockout;
      end
   end

   // ---------------------------------------------------------------
   // Configuration menu, password and commit
   // ---------------------------------------------------------------
   always_comb begin
      next_menu_state = menu_state;
      next_pend_sched = pend_sched;
      next_pend_time = pend_time;
      unique case (menu_state)
         menu_closed:
            if (menu_request && (standby_active || state == st_lockout))
               next_menu_state = menu_digit1;
         menu_digit1:
            if (key_valid)
               next_menu_state =
                  (key_digit == valve_prove_pkg::PASS_DIGIT_FIRST) ?
                  menu_digit2 : menu_closed;
         menu_digit2:
            if (key_valid)
               next_menu_state =
                  (key_digit == valve_prove_pkg::PASS_DIGIT_SECOND) ?
                  menu_open : menu_closed;
         menu_open: begin
            if (menu_exit)
               next_menu_state = menu_closed;
            if (schedule_set && schedule_sel <= valve_prove_pkg::sched_split)
               next_pend_sched = schedule_sel;
            if (time_up && pend_time < valve_prove_pkg::TEST_TIME_MAX)
               next_pend_time = pend_time + time_step(pend_time, 1'b1);
            else if (time_down && pend_time != 12'h000)
               next_pend_time = pend_time - time_step(pend_time, 1'b0);
         end
         default: next_menu_state = menu_closed;
      endcase
      next_hold_cnt = button_on ?
         (hold_cnt == HOLD_CYCLES ? hold_cnt : hold_cnt + 32'h1) : '0;
      next_schedule = commit ? pend_sched : schedule;
      next_test_time = commit ? pend_time : test_time_s;
   end

   // Commit fires once, the cycle the hold reaches its length
   assign commit = menu_state == menu_open && button_on &&
                   hold_cnt == HOLD_CYCLES - 1;

   // Menu registers and committed settings
   always_ff @(posedge clk) begin
      if (srst) begin
         menu_state <= menu_closed;
         pend_sched <= valve_prove_pkg::sched_never;
         pend_time <= valve_prove_pkg::TEST_TIME_RESET;
         hold_cnt <= '0;
         schedule <= valve_prove_pkg::sched_never;
         test_time_s <= valve_prove_pkg::TEST_TIME_RESET;
         menu_unlocked <= 1'b0;
      end else begin
         menu_state <= next_menu_state;
         pend_sched <= next_pend_sched;
         pend_time <= next_pend_time;
         hold_cnt <= next_hold_cnt;
         schedule <= next_schedule;
         test_time_s <= next_test_time;
         menu_unlocked <= next_menu_state == menu_open;
      end
   end

   // ---------------------------------------------------------------
   // Checks
   // ---------------------------------------------------------------
   logic [31:0] on_cnt;

   // Cycles for which one valve output has stood on
   always_ff @(posedge clk) begin
      if (srst)
         on_cnt <= '0;
      else
         on_cnt <= (upstream_valve_output || downstream_valve_output) ?
                   on_cnt + 32'h1 : '0;
   end

   property p_valve_alone;
      @(posedge clk) disable iff (srst)
         downstream_valve_output |-> !upstream_valve_output;
   endproperty
   a_valve_alone: assert property (p_valve_alone)
      else $error("both valve outputs on together");

   property p_open_length;
      @(posedge clk) disable iff (srst)
         on_cnt <= 4 * TICKS_PER_SEC;
   endproperty
   a_open_length: assert property (p_open_length)
      else $error("valve output held beyond its open time");

   property p_settle_ignores;
      @(posedge clk) disable iff (srst)
         state == st_vent_settle && sw_on && !demand_fault
         |=> state != st_lockout;
   endproperty
   a_settle_ignores: assert property (p_settle_ignores)
      else $error("switch acted on during settling");

   property p_low_fail;
      @(posedge clk) disable iff (srst)
         state == st_vent_watch && sw_on |=> state == st_lockout ##1
            lockout_active && !downstream_valve_output;
   endproperty
   a_low_fail: assert property (p_low_fail)
      else $error("low pressure leak not locked out");

   property p_high_fail;
      @(posedge clk) disable iff (srst)
         state == st_fill_watch && !sw_on |=> state == st_lockout;
   endproperty
   a_high_fail: assert property (p_high_fail)
      else $error("high pressure leak not locked out");

   property p_lockout_valves;
      @(posedge clk) disable iff (srst)
         lockout_active |-> !upstream_valve_output &&
                            !downstream_valve_output;
   endproperty
   a_lockout_valves: assert property (p_lockout_valves)
      else $error("valve output on during lockout");

   property p_never_idle;
      @(posedge clk) disable iff (srst)
         state == st_idle && schedule == valve_prove_pkg::sched_never &&
         !demand_fault |=> state == st_idle;
   endproperty
   a_never_idle: assert property (p_never_idle)
      else $error("seat test started with schedule never");

   property p_menu_gate;
      @(posedge clk) disable iff (srst)
         menu_state == menu_closed && !standby_active &&
         state != st_lockout |=> menu_state == menu_closed;
   endproperty
   a_menu_gate: assert property (p_menu_gate)
      else $error("menu entered outside standby or lockout");

   property p_bad_digit;
      @(posedge clk) disable iff (srst)
         menu_state == menu_digit1 && key_valid &&
         key_digit != valve_prove_pkg::PASS_DIGIT_FIRST |=>
         menu_state == menu_closed ##1
         !menu_unlocked;
   endproperty
   a_bad_digit: assert property (p_bad_digit)
      else $error("wrong first password digit accepted");

   property p_demand_clash;
      @(posedge clk) disable iff (srst)
         prepurge_active && plain_on && proving_on |=>
         state == st_lockout;
   endproperty
   a_demand_clash: assert property (p_demand_clash)
      else $error("both demands in pre-purge without lockout");

endmodule

//--- core/valve_prove_pkg.sv
// Constants and types shared by the valve seat proving sequencer
package valve_prove_pkg;

   // ---------------------------------------------------------------
   // Proving schedule choices
   // ---------------------------------------------------------------
   typedef enum logic [2:0] {
      sched_never  = 3'h0,
      sched_before = 3'h1,
      sched_after  = 3'h2,
      sched_both   = 3'h3,
      sched_split  = 3'h4
   } schedule_type;

   // ---------------------------------------------------------------
   // Timebase
   // ---------------------------------------------------------------
   localparam int unsigned CLK_PERIOD_NS = 25;
   localparam int unsigned SECOND_NS = 1_000_000_000;
   localparam int unsigned ONE_SEC_CYCLES = SECOND_NS / CLK_PERIOD_NS;

   // ---------------------------------------------------------------
   // Phase lengths in seconds, commit hold in seconds and in cycles
   // ---------------------------------------------------------------
   localparam logic [11:0] FILL_TIME_S = 12'h004;
   localparam logic [11:0] SETTLE_TIME_S = 12'h003;
   localparam int unsigned COMMIT_HOLD_S = 5;
   localparam int unsigned COMMIT_HOLD_CYCLES = COMMIT_HOLD_S * ONE_SEC_CYCLES;

   // ---------------------------------------------------------------
   // Test time setting: width, limits and step breakpoints
   // ---------------------------------------------------------------
   localparam int unsigned TIME_W = 12;
   localparam logic [11:0] TEST_TIME_RESET = 12'h000;
   localparam logic [11:0] TEST_TIME_MAX = 12'he10;
   localparam logic [11:0] STEP_BREAK_LOW = 12'h03c;
   localparam logic [11:0] STEP_BREAK_HIGH = 12'h258;
   localparam logic [11:0] STEP_FINE = 12'h001;
   localparam logic [11:0] STEP_MID = 12'h00a;
   localparam logic [11:0] STEP_COARSE = 12'h03c;

   // ---------------------------------------------------------------
   // Password digits
   // ---------------------------------------------------------------
   localparam logic [3:0] PASS_DIGIT_FIRST = 4'h7;
   localparam logic [3:0] PASS_DIGIT_SECOND = 4'h8;

   // ---------------------------------------------------------------
   // Positions of the pin inputs in the synchroniser vector
   // ---------------------------------------------------------------
   localparam int unsigned PIN_SWITCH = 0;
   localparam int unsigned PIN_PLAIN = 1;
   localparam int unsigned PIN_PROVING = 2;
   localparam int unsigned PIN_BUTTON = 3;
   localparam int unsigned PIN_COUNT = 4;

endpackage

//--- bench/valve_train_model.sv
// Gas valve pair with the pressure switch on the space between them
`timescale 1ns/1ps

module valve_train_model (
   input wire logic clk,
   input wire logic up_open,
   input wire logic down_open,
   input wire logic leak_up,
   input wire logic leak_down,
   output logic pressure_switch
);
   logic next_pressure;

   initial pressure_switch = 1'b0;

   // ------------
   // Space pressure
   // ------------
   // Venting wins over filling; leaks act only with both seats shut
   always_comb begin
      next_pressure = pressure_switch;
      if (down_open) begin
         next_pressure = 1'b0;
      end else if (up_open || leak_up) begin
         next_pressure = 1'b1;
      end else if (leak_down) begin
         next_pressure = 1'b0;
      end
   end

   always @(posedge clk) begin
      pressure_switch <= next_pressure;
   end
endmodule

//--- bench/valve_proving_sequencer_tb_top.sv
// Self-checking bench for the valve seat proving sequencer
`timescale 1ns/1ps

module valve_proving_sequencer_tb_top;
   localparam int TPS = 8;
   localparam int HOLD = 40;
   typedef struct packed {
      logic [2:0] sch;
      logic at_end;
      logic [1:0] first;
      logic [1:0] second;
   } row_type;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic sw;
   logic plain_dem = 1'b0, prov_dem = 1'b0, button = 1'b0;
   logic standby_active = 1'b1, prepurge_active = 1'b0;
   logic run_active = 1'b0, menu_request = 1'b0, menu_exit = 1'b0;
   logic key_valid = 1'b0, schedule_set = 1'b0;
   logic time_up = 1'b0, time_down = 1'b0;
   logic [3:0] key_digit = 4'h0;
   logic [2:0] schedule_sel = 3'h0;
   logic leak_up = 1'b0, leak_down = 1'b0;
   logic up, down, lock, busy, unl;
   logic [2:0] sched;
   logic [11:0] ttime;
   int n_errors = 0;
   int num_checks = 0;
   int cyc = 0;
   int w;
   // Codes: 1 downstream first, 2 upstream; 0 none
   row_type rows [10] = '{
      '{3'h0, 1'b0, 2'h0, 2'h0}, '{3'h0, 1'b1, 2'h0, 2'h0},
      '{3'h1, 1'b0, 2'h1, 2'h2}, '{3'h1, 1'b1, 2'h0, 2'h0},
      '{3'h2, 1'b0, 2'h0, 2'h0}, '{3'h2, 1'b1, 2'h1, 2'h2},
      '{3'h3, 1'b0, 2'h1, 2'h2}, '{3'h3, 1'b1, 2'h1, 2'h2},
      '{3'h4, 1'b0, 2'h2, 2'h0}, '{3'h4, 1'b1, 2'h1, 2'h0}};

   always #12.5 clk = ~clk;

   valve_proving_sequencer #(.TICKS_PER_SEC(TPS), .HOLD_CYCLES(HOLD))
   i_valve_proving_sequencer (
      .clk(clk), .srst(srst), .proving_pressure_switch(sw),
      .plain_demand_input(plain_dem), .proving_demand_input(prov_dem),
      .reset_button(button), .standby_active(standby_active),
      .prepurge_active(prepurge_active), .run_active(run_active),
      .menu_request(menu_request), .menu_exit(menu_exit),
      .key_valid(key_valid), .key_digit(key_digit),
      .schedule_set(schedule_set), .schedule_sel(schedule_sel),
      .time_up(time_up), .time_down(time_down),
      .upstream_valve_output(up), .downstream_valve_output(down),
      .lockout_active(lock), .proving_busy(busy), .menu_unlocked(unl),
      .schedule(sched), .test_time_s(ttime));

   valve_train_model i_valve_train_model (
      .clk(clk), .up_open(up), .down_open(down), .leak_up(leak_up),
      .leak_down(leak_down), .pressure_switch(sw));

   // ------------
   // Shared tasks
   // ------------
   task automatic conclude();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [11:0] seen,
                        input logic [11:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
   endtask

   // One-cycle pulse: 0 request, 1 exit, 2 set, 3 up, 4 down
   task automatic pulse(input int k);
      @(posedge clk);
      case (k)
         0: menu_request <= 1'b1;
         1: menu_exit <= 1'b1;
         2: schedule_set <= 1'b1;
         3: time_up <= 1'b1;
         default: time_down <= 1'b1;
      endcase
      @(posedge clk);
      {menu_request, menu_exit, schedule_set, time_up, time_down} <= 5'h00;
   endtask

   task automatic unlock(input logic [3:0] d2);
      pulse(0);
      key_valid <= 1'b1;
      key_digit <= 4'h7;
      @(posedge clk);
      key_digit <= d2;
      @(posedge clk);
      key_valid <= 1'b0;
      tick(1);
   endtask

   task automatic commit(input int n);
      @(posedge clk);
      button <= 1'b1;
      tick(n);
      button <= 1'b0;
      tick(4);
   endtask

   // Operator keeps never until the final choice
   task automatic cfg(input logic [2:0] s, input int ups, input int dns);
      standby_active <= 1'b1;
      unlock(4'h8);
      schedule_sel <= s;
      pulse(2);
      repeat (ups) pulse(3);
      repeat (dns) pulse(4);
      commit(HOLD + 4);
      pulse(1);
      @(negedge clk);
      check("schedule", 12'(sched), 12'(s));
      @(posedge clk);
   endtask

   task automatic zero_check();
      check("outputs", 12'({up, down, lock, busy, unl}), 12'h000);
      check("schedule", 12'(sched), 12'h000);
      check("test_time", ttime, 12'h000);
   endtask

   task automatic phase(input logic [1:0] exp, output int wt);
      int n;
      logic [1:0] seen;
      wt = 0;
      while ({up, down} === 2'h0 && wt < 70) begin
         @(negedge clk);
         wt++;
      end
      seen = {up, down};
      check("valve", 12'(seen), 12'(exp));
      if (seen !== 2'h0) begin
         check("busy", 12'(busy), 12'h001);
         n = 0;
         while ({up, down} === seen && n < 100) begin
            @(negedge clk);
            n++;
         end
         check("open_time", 12'(n), 12'(4 * TPS));
      end
   endtask

   task automatic lock_fault(input int lo, input int hi);
      int n;
      n = 0;
      while (lock !== 1'b1 && n < 80) begin
         @(negedge clk);
         n++;
      end
      check("lock_delay", 12'(n >= lo && n <= hi), 12'h001);
      repeat (16) begin
         @(negedge clk);
         check("held", 12'({up, down, lock}), 12'h001);
      end
      @(posedge clk);
      {leak_up, leak_down, prepurge_active, plain_dem, prov_dem} <= 5'h00;
      button <= 1'b1;
      tick(3);
      button <= 1'b0;
      n = 0;
      while (lock !== 1'b0 && n < 20) begin
         @(negedge clk);
         n++;
      end
      check("cleared", 12'(lock), 12'h000);
      @(posedge clk);
   endtask

   // ------------
   // Timeout
   // ------------
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_errors++;
         conclude();
      end
   end

   // ------------
   // Main sequence
   // ------------
   initial begin
      tick(5);
      srst <= 1'b0;
      @(negedge clk);
      zero_check();
      unlock(4'h8);
      pulse(3);
      commit(HOLD - 8);
      @(negedge clk);
      check("early_commit", ttime, 12'h000);
      pulse(1);
      cfg(3'h0, 64, 1);
      check("time_a", ttime, 12'h064);
      cfg(3'h0, 51, 0);
      check("time_b", ttime, 12'h294);
      cfg(3'h0, 0, 2);
      check("time_c", ttime, 12'h24e);
      foreach (rows[i]) begin
         if (i % 2 == 0) begin
            cfg(rows[i].sch, 0, (i == 0) ? 112 : 0);
         end
         standby_active <= 1'b0;
         if (rows[i].at_end) begin
            run_active <= 1'b1;
            tick(3);
            run_active <= 1'b0;
         end else begin
            prepurge_active <= 1'b1;
         end
         phase(rows[i].first, w);
         if (rows[i].second != 2'h0) begin
            phase(rows[i].second, w);
            check("gap", 12'(w >= 4 * TPS && w <= 4 * TPS + 3), 12'h001);
         end
         while (busy !== 1'b0 && w < 300) begin
            @(negedge clk);
            w++;
         end
         check("idle", 12'({lock, busy}), 12'h000);
         @(posedge clk);
         prepurge_active <= 1'b0;
      end
      // Seat leaks under the split schedule
      @(posedge clk);
      leak_down <= 1'b1;
      prepurge_active <= 1'b1;
      phase(2'h2, w);
      lock_fault(3 * TPS, 5 * TPS);
      leak_up <= 1'b1;
      run_active <= 1'b1;
      tick(3);
      run_active <= 1'b0;
      phase(2'h1, w);
      lock_fault(3 * TPS, 5 * TPS);
      // Demand conflict, menu entry from lockout
      plain_dem <= 1'b1;
      prov_dem <= 1'b1;
      tick(4);
      prepurge_active <= 1'b1;
      tick(8);
      unlock(4'h8);
      @(negedge clk);
      check("menu_lockout", 12'(unl), 12'h001);
      pulse(1);
      lock_fault(0, 0);
      unlock(4'h8);
      @(negedge clk);
      check("menu_busy", 12'(unl), 12'h000);
      @(posedge clk);
      standby_active <= 1'b1;
      unlock(4'h9);
      @(negedge clk);
      check("wrong_digit", 12'(unl), 12'h000);
      // Wrong first digit closes the menu at once
      @(posedge clk);
      pulse(0);
      key_valid <= 1'b1;
      key_digit <= 4'h8;
      @(posedge clk);
      key_valid <= 1'b0;
      tick(1);
      @(negedge clk);
      check("wrong_first", 12'(unl), 12'h000);
      @(posedge clk);
      cfg(3'h0, 0, 0);
      standby_active <= 1'b0;
      prov_dem <= 1'b1;
      tick(4);
      prepurge_active <= 1'b1;
      lock_fault(0, 8);
      standby_active <= 1'b1;
      unlock(4'h8);
      srst <= 1'b1;
      tick(2);
      srst <= 1'b0;
      @(negedge clk);
      zero_check();
      conclude();
   end
endmodule
